// ### rtl/dmatr_ctrl.sv
// Controller end: terminal count, end-of-process sampling and refresh drive.
`timescale 1ns/1ns
`default_nettype none
module dmatr_ctrl
	import dmatr_pkg::*;
#(
	parameter bit HAS_SLAVE_TERMINATE_INPUT_MODE  = 1'b1,
	parameter int XFER_CYCLES = DMATR_XFER_CYCLES,
	parameter int REF_CYCLES  = DMATR_REF_CYCLES
) (
	input  wire logic clk_in,
	input  wire logic reset_n_in,
	dmatr_if.ctrl     link,
	input  wire logic dma_active_in,
	input  wire logic xfer_start_in,
	input  wire logic count_last_in,
	input  wire logic autoinit_in,
	input  wire logic refresh_req_in,
	output logic      xfer_busy_out,
	output logic      xfer_done_out,
	output logic      terminated_out,
	output logic      refresh_busy_out,
	output logic      ext_refresh_out
);
	dmatr_xfer_state_type   x_state_r;
	dmatr_ref_state_type    r_state_r;
	logic [DMATR_CNT_W-1:0] x_cnt_r;
	logic [DMATR_CNT_W-1:0] r_cnt_r;
	logic                   last_r;
	logic                   auto_r;
	logic                   eop_meta_r;
	logic                   eop_sync_r;
	logic                   ref_meta_r;
	logic                   ref_sync_r;
	logic                   eop_hit;
	logic                   ref_grant;

	// Synchronise end-of-process.
	// (RQ15) Two-flop input sync.
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			eop_meta_r <= 1'b0;
			eop_sync_r <= 1'b0;
		end else begin
			eop_meta_r <= link.eop_line;
			eop_sync_r <= eop_meta_r;
		end
	end

	// The refresh line idles high, so its sync resets high and no false master refresh follows reset.
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			ref_meta_r <= 1'b1;
			ref_sync_r <= 1'b1;
		end else begin
			ref_meta_r <= link.refresh_line_n;
			ref_sync_r <= ref_meta_r;
		end
	end

	// The sync lags by two edges, so the first data cycles after turning the pin round still show our own low drive.
	// (RQ15) Ignore own drive.
	// (RQ2) Sample during transfer.
	assign eop_hit = HAS_SLAVE_TERMINATE_INPUT_MODE && link.ctrl_eop_oe_n && eop_sync_r && (x_state_r == DMATR_X_DATA);

	// A refresh never starts on the edge that a transfer is granted, so the two never share the bus.
	assign ref_grant = refresh_req_in && (x_state_r == DMATR_X_IDLE) && !xfer_start_in && ref_sync_r;

	// Transfer sequencing, address enable and terminal count.
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			x_state_r         <= DMATR_X_IDLE;
			x_cnt_r           <= '0;
			last_r            <= 1'b0;
			auto_r            <= 1'b0;
			link.ctrl_aen     <= 1'b0;
			link.ctrl_eop_out <= 1'b0;
			xfer_done_out     <= 1'b0;
			terminated_out    <= 1'b0;
		end else begin
			xfer_done_out  <= 1'b0;
			terminated_out <= 1'b0;
			unique case (x_state_r)
				DMATR_X_IDLE: begin
					link.ctrl_eop_out <= 1'b0;
					if (xfer_start_in && dma_active_in && (r_state_r == DMATR_R_IDLE) && ref_sync_r) begin
						x_state_r     <= DMATR_X_ADDR;
						link.ctrl_aen <= 1'b1;
						last_r        <= count_last_in;
						auto_r        <= autoinit_in;
					end
				end
				DMATR_X_ADDR: begin
					x_state_r <= DMATR_X_DATA;
					x_cnt_r   <= DMATR_CNT_W'(XFER_CYCLES - 1);
					// (RQ3) Count after address.
					// (RQ8) Same in output variant.
					link.ctrl_eop_out <= last_r;
				end
				DMATR_X_DATA: begin
					if (eop_hit || (x_cnt_r == '0)) begin
						x_state_r      <= DMATR_X_END;
						terminated_out <= eop_hit;
						// (RQ5) Autoinit early drop.
						if (auto_r) begin
							link.ctrl_eop_out <= 1'b0;
						end
					end else begin
						x_cnt_r <= x_cnt_r - 1'b1;
					end
				end
				DMATR_X_END: begin
					x_state_r         <= DMATR_X_IDLE;
					link.ctrl_aen     <= 1'b0;
					xfer_done_out     <= 1'b1;
					// (RQ4) Drop with address enable.
					link.ctrl_eop_out <= 1'b0;
				end
			endcase
		end
	end

	// Pin direction: input only while a non-final data phase runs on an active channel.
	// The output-only variant never turns the pin round, so its slaves cannot end a transfer early.
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			// (RQ7) Output after reset.
			link.ctrl_eop_oe_n <= 1'b0;
		end else if (!dma_active_in || !HAS_SLAVE_TERMINATE_INPUT_MODE) begin
			// (RQ6) Idle drives low.
			link.ctrl_eop_oe_n <= 1'b0;
		end else if (x_state_r == DMATR_X_ADDR) begin
			link.ctrl_eop_oe_n <= !last_r;
		end else if (x_state_r == DMATR_X_DATA && !(eop_hit || (x_cnt_r == '0))) begin
			link.ctrl_eop_oe_n <= link.ctrl_eop_oe_n;
		end else begin
			link.ctrl_eop_oe_n <= 1'b0;
		end
	end

	// Busy follows a start at once; a start refused for refresh shows one busy cycle.
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			xfer_busy_out <= 1'b0;
		end else begin
			xfer_busy_out <= (x_state_r != DMATR_X_IDLE) || (xfer_start_in && dma_active_in);
		end
	end

	// Own refresh cycle: drive low for the whole cycle, then let the sync settle before listening again.
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			r_state_r           <= DMATR_R_IDLE;
			r_cnt_r             <= '0;
			// (RQ12) Released in reset.
			link.ctrl_ref_oe_n  <= 1'b1;
			link.ctrl_ref_n_out <= 1'b1;
		end else begin
			unique case (r_state_r)
				DMATR_R_IDLE: begin
					// (RQ10) Internal request only.
					if (ref_grant) begin
						r_state_r           <= DMATR_R_DRIVE;
						r_cnt_r             <= DMATR_CNT_W'(REF_CYCLES - 1);
						link.ctrl_ref_oe_n  <= 1'b0;
						link.ctrl_ref_n_out <= 1'b0;
					end
				end
				DMATR_R_DRIVE: begin
					// (RQ9) Hold for cycle.
					if (r_cnt_r == '0) begin
						r_state_r           <= DMATR_R_REL;
						r_cnt_r             <= DMATR_CNT_W'(DMATR_SYNC_LAG);
						link.ctrl_ref_oe_n  <= 1'b1;
						link.ctrl_ref_n_out <= 1'b1;
					end else begin
						r_cnt_r <= r_cnt_r - 1'b1;
					end
				end
				DMATR_R_REL: begin
					if (r_cnt_r == '0) begin
						r_state_r <= DMATR_R_IDLE;
					end else begin
						r_cnt_r <= r_cnt_r - 1'b1;
					end
				end
				default: begin
					r_state_r           <= DMATR_R_IDLE;
					link.ctrl_ref_oe_n  <= 1'b1;
					link.ctrl_ref_n_out <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			refresh_busy_out <= 1'b0;
			ext_refresh_out  <= 1'b0;
		end else begin
			refresh_busy_out <= (r_state_r == DMATR_R_DRIVE) || ((r_state_r == DMATR_R_IDLE) && ref_grant);
			// A master's refresh is reported only once our own drive has settled out of the sync.
			// (RQ11) Listen to master.
			ext_refresh_out  <= (r_state_r == DMATR_R_IDLE) && !ref_sync_r;
		end
	end
endmodule // dmatr_ctrl
`default_nettype wire

// ### rtl/dmatr_pkg.sv
// Constants and state types shared by both ends of the termination and refresh link.
// Operation
// (RQ1) Slave asserts end-of-process to stop early.
// (RQ2) Controller samples end-of-process, terminates when asserted.
// (RQ3) Terminal count follows new address on expiry.
// (RQ4) Terminal count held until address enable drops.
// (RQ5) Autoinit: terminal count drops before address enable.
// (RQ6) No channel active: pin output, driven low.
// (RQ7) After reset: pin output and inactive.
// (RQ8) Output-only variant keeps same terminal-count timing.
// (RQ9) Controller refresh drives refresh line whole cycle.
// (RQ10) Refresh driven only for internal request, else released.
// (RQ11) Sixteen-bit master pulls refresh low; controller listens.
// (RQ12) Refresh line high impedance during reset.
// (RQ13) Memory slaves keep data lines quiet during refresh.
// (RQ14) Refresh routes low address bits to rows.
// (RQ15) Synchronise end-of-process; ignore while pin drives.
package dmatr_pkg;
	localparam int DMATR_CNT_W       = 8;
	localparam int DMATR_XFER_CYCLES = 4;
	localparam int DMATR_REF_CYCLES  = 6;
	localparam int DMATR_EOP_CYCLES  = 2;
	localparam int DMATR_SYNC_LAG    = 2;

	typedef enum logic [1:0] {
		DMATR_X_IDLE = 2'b00,
		DMATR_X_ADDR = 2'b01,
		DMATR_X_DATA = 2'b10,
		DMATR_X_END  = 2'b11
	} dmatr_xfer_state_type;

	typedef enum logic [1:0] {
		DMATR_R_IDLE  = 2'b00,
		DMATR_R_DRIVE = 2'b01,
		DMATR_R_REL   = 2'b10
	} dmatr_ref_state_type;
endpackage

// ### rtl/dmatr_if.sv
// Link between the controller end and the bus partner end, with wire resolution.
`timescale 1ns/1ns
`default_nettype none
interface dmatr_if;
	logic ctrl_eop_out;
	logic ctrl_eop_oe_n;
	logic ctrl_ref_n_out;
	logic ctrl_ref_oe_n;
	logic ctrl_aen;
	logic peer_eop_out;
	logic peer_eop_oe_n;
	logic peer_ref_n_out;
	logic peer_ref_oe_n;
	logic eop_line;
	logic refresh_line_n;

	// End-of-process is pulled low when nobody drives; refresh is pulled high.
	assign eop_line       = (!ctrl_eop_oe_n && ctrl_eop_out) || (!peer_eop_oe_n && peer_eop_out);
	assign refresh_line_n = !((!ctrl_ref_oe_n && !ctrl_ref_n_out) || (!peer_ref_oe_n && !peer_ref_n_out));

	modport ctrl (
		output ctrl_eop_out,
		output ctrl_eop_oe_n,
		output ctrl_ref_n_out,
		output ctrl_ref_oe_n,
		output ctrl_aen,
		input  eop_line,
		input  refresh_line_n
	);
	modport peer (
		output peer_eop_out,
		output peer_eop_oe_n,
		output peer_ref_n_out,
		output peer_ref_oe_n,
		input  ctrl_aen,
		input  eop_line,
		input  refresh_line_n
	);
endinterface
`default_nettype wire

// ### rtl/dmatr_peer.sv
// Bus partner end: a slave that terminates early and a master that requests refresh.
`timescale 1ns/1ns
`default_nettype none
module dmatr_peer
	import dmatr_pkg::*;
#(
	parameter int EOP_CYCLES = DMATR_EOP_CYCLES,
	parameter int REF_CYCLES = DMATR_REF_CYCLES
) (
	input  wire logic clk_in,
	input  wire logic reset_n_in,
	dmatr_if.peer     link,
	input  wire logic terminate_req_in,
	input  wire logic refresh_req_in,
	output logic      tc_seen_out,
	output logic      refresh_seen_out,
	output logic      row_refresh_out,
	output logic      data_drive_en_out
);
	logic [DMATR_CNT_W-1:0] e_cnt_r;
	logic [DMATR_CNT_W-1:0] r_cnt_r;
	logic                   term_pend_r;
	logic                   aen_meta_r;
	logic                   aen_sync_r;
	logic                   eop_meta_r;
	logic                   eop_sync_r;
	logic                   ref_meta_r;
	logic                   ref_sync_r;

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			aen_meta_r <= 1'b0;
			aen_sync_r <= 1'b0;
			eop_meta_r <= 1'b0;
			eop_sync_r <= 1'b0;
			ref_meta_r <= 1'b1;
			ref_sync_r <= 1'b1;
		end else begin
			aen_meta_r <= link.ctrl_aen;
			aen_sync_r <= aen_meta_r;
			eop_meta_r <= link.eop_line;
			eop_sync_r <= eop_meta_r;
			ref_meta_r <= link.refresh_line_n;
			ref_sync_r <= ref_meta_r;
		end
	end

	// A request made outside a transfer waits for the next one; its drive lasts EOP_CYCLES cycles or until that transfer ends.
	// (RQ1) Early stop drive.
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			term_pend_r        <= 1'b0;
			e_cnt_r            <= '0;
			link.peer_eop_oe_n <= 1'b1;
			link.peer_eop_out  <= 1'b0;
		end else if (!link.peer_eop_oe_n) begin
			if (e_cnt_r == '0 || !aen_sync_r) begin
				link.peer_eop_oe_n <= 1'b1;
				link.peer_eop_out  <= 1'b0;
			end else begin
				e_cnt_r <= e_cnt_r - 1'b1;
			end
		end else if ((term_pend_r || terminate_req_in) && aen_sync_r) begin
			term_pend_r        <= 1'b0;
			e_cnt_r            <= DMATR_CNT_W'(EOP_CYCLES - 1);
			link.peer_eop_oe_n <= 1'b0;
			link.peer_eop_out  <= 1'b1;
		end else begin
			term_pend_r <= term_pend_r || terminate_req_in;
		end
	end

	// (RQ11) Master starts refresh.
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			r_cnt_r             <= '0;
			link.peer_ref_oe_n  <= 1'b1;
			link.peer_ref_n_out <= 1'b1;
		end else if (!link.peer_ref_oe_n) begin
			if (r_cnt_r == '0) begin
				link.peer_ref_oe_n  <= 1'b1;
				link.peer_ref_n_out <= 1'b1;
			end else begin
				r_cnt_r <= r_cnt_r - 1'b1;
			end
		end else if (refresh_req_in && ref_sync_r && !aen_sync_r) begin
			r_cnt_r             <= DMATR_CNT_W'(REF_CYCLES - 1);
			link.peer_ref_oe_n  <= 1'b0;
			link.peer_ref_n_out <= 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			tc_seen_out       <= 1'b0;
			refresh_seen_out  <= 1'b0;
			row_refresh_out   <= 1'b0;
			data_drive_en_out <= 1'b0;
		end else begin
			tc_seen_out       <= eop_sync_r && link.peer_eop_oe_n;
			refresh_seen_out  <= !ref_sync_r;
			// (RQ14) Rows from address.
			row_refresh_out   <= !ref_sync_r || !link.peer_ref_oe_n;
			// (RQ13) Quiet during refresh.
			data_drive_en_out <= ref_sync_r && link.peer_ref_oe_n;
		end
	end
endmodule // dmatr_peer
`default_nettype wire

// ### tb/dmatr_checker.sv
// Assertions on the resolved termination and refresh link.
`timescale 1ns/1ns
`default_nettype none
module dmatr_checker #(
	parameter int XFER_CYCLES = 4
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic ctrl_eop_out,
	input wire logic ctrl_eop_oe_n,
	input wire logic ctrl_ref_n_out,
	input wire logic ctrl_ref_oe_n,
	input wire logic ctrl_aen,
	input wire logic peer_ref_oe_n,
	input wire logic refresh_line_n
);
	// An early stop only shortens a transfer, so this is an upper bound.
	localparam int XF_MAX = XFER_CYCLES + 2;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!reset_n_in);
	sequence s_ref_drive;
		(!ctrl_ref_oe_n && !ctrl_ref_n_out && !refresh_line_n) [*6];
	endsequence
	sequence s_ref_gap;
		ctrl_ref_oe_n [*2];
	endsequence
	a_reset_quiet_link: // quiet after reset.
		assert property (disable iff (1'b0) !reset_n_in |=> !ctrl_eop_oe_n && !ctrl_eop_out && ctrl_ref_oe_n && !ctrl_aen)
		else $error("Link not quiet after reset.");
	a_idle_eop_low: // idle drives low.
		assert property (!ctrl_aen |-> !ctrl_eop_oe_n && !ctrl_eop_out)
		else $error("Idle end-of-process not driven low.");
	a_tc_after_addr: // after address.
		assert property ($rose(ctrl_eop_out) |-> ctrl_aen && $past(ctrl_aen))
		else $error("Terminal count before address cycle.");
	a_tc_hold_aen: // held with enable.
		assert property ($fell(ctrl_eop_out) |-> ##[0:1] !ctrl_aen)
		else $error("Terminal count dropped too early.");
	a_xfer_bounded_len: // bounded transfer.
		assert property ($rose(ctrl_aen) |-> ##[1:XF_MAX] !ctrl_aen)
		else $error("Transfer ran too long.");
	a_ref_internal_only: // internal drive only.
		assert property (!ctrl_ref_oe_n |-> !ctrl_aen && !ctrl_ref_n_out)
		else $error("Refresh driven outside own refresh.");
	a_ref_whole_cycle: // whole cycle low.
		assert property ($fell(ctrl_ref_oe_n) |-> s_ref_drive ##1 s_ref_gap)
		else $error("Refresh drive length wrong.");
	a_peer_ref_idle: // master refresh alone.
		assert property (!peer_ref_oe_n |-> ctrl_ref_oe_n && !ctrl_aen)
		else $error("Master refresh overlaps controller.");
endmodule // dmatr_checker
`default_nettype wire

// ### tb/dma_termination_and_refresh_tb_top.sv
// Self-checking bench for both ends of the termination and refresh link.
`timescale 1ns/1ns
`default_nettype none
module dma_termination_and_refresh_tb_top;
	import dmatr_pkg::*;
	localparam int XC = 10;
	logic clk_in = 1'b0, reset_n_in = 1'b0, act = 1'b1, start = 1'b0, last = 1'b0, auto = 1'b0;
	logic c_ref = 1'b0, term = 1'b0, p_ref = 1'b0, xbusy, done, termd, rbusy, ext, tcs, rsn, row, dde;
	logic s_tc, s_term, s_ext, s_own, s_aen, s_oe2;
	int error_cnt = 0;
	int checks = 0;
	int low_n;
	dmatr_if lk();
	dmatr_if lk2();
	// The output-only variant shares the stimulus; its far end is tied idle.
	assign lk2.peer_eop_out   = 1'b0;
	assign lk2.peer_eop_oe_n  = 1'b1;
	assign lk2.peer_ref_n_out = 1'b1;
	assign lk2.peer_ref_oe_n  = 1'b1;
	dmatr_ctrl #(.HAS_SLAVE_TERMINATE_INPUT_MODE(1'b0), .XFER_CYCLES(XC)) u_dmatr_ctrl_tco (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.link(lk2.ctrl), .dma_active_in(act), .xfer_start_in(start), .count_last_in(last), .autoinit_in(auto),
		.refresh_req_in(c_ref), .xfer_busy_out(), .xfer_done_out(), .terminated_out(), .refresh_busy_out(),
		.ext_refresh_out());
	dmatr_ctrl #(.XFER_CYCLES(XC)) u_dmatr_ctrl (.clk_in(clk_in), .reset_n_in(reset_n_in), .link(lk.ctrl),
		.dma_active_in(act), .xfer_start_in(start), .count_last_in(last), .autoinit_in(auto),
		.refresh_req_in(c_ref), .xfer_busy_out(xbusy), .xfer_done_out(done), .terminated_out(termd),
		.refresh_busy_out(rbusy), .ext_refresh_out(ext));
	dmatr_peer u_dmatr_peer (.clk_in(clk_in), .reset_n_in(reset_n_in), .link(lk.peer), .terminate_req_in(term),
		.refresh_req_in(p_ref), .tc_seen_out(tcs), .refresh_seen_out(rsn), .row_refresh_out(row),
		.data_drive_en_out(dde));
	dmatr_checker #(.XFER_CYCLES(XC)) u_dmatr_checker (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.ctrl_eop_out(lk.ctrl_eop_out), .ctrl_eop_oe_n(lk.ctrl_eop_oe_n), .ctrl_ref_n_out(lk.ctrl_ref_n_out),
		.ctrl_ref_oe_n(lk.ctrl_ref_oe_n), .ctrl_aen(lk.ctrl_aen), .peer_ref_oe_n(lk.peer_ref_oe_n),
		.refresh_line_n(lk.refresh_line_n));
	always #25 clk_in = ~clk_in;
	// Sampled on the falling edge, away from the bench's own input changes.
	always @(negedge clk_in) begin
		low_n += int'(!lk.refresh_line_n);
		s_tc |= tcs;
		s_term |= termd;
		s_ext |= ext;
		s_own |= !lk.ctrl_ref_oe_n;
		s_aen |= lk.ctrl_aen;
		s_oe2 |= lk2.ctrl_eop_oe_n;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#5;
	endtask
	task automatic clr;
		{s_tc, s_term, s_ext, s_own, s_aen, s_oe2} = 6'h00;
		low_n = 0;
	endtask
	task automatic chk1(input string nm, input logic exp, input logic got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %b seen %b", nm, exp, got);
		end
	endtask
	task automatic chkn(input string nm, input int exp, input int got);
		checks++;
		if (got != exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %0d seen %0d", nm, exp, got);
		end
	endtask
	task automatic report_and_stop;
		$display("Checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// The bound stops a silent hang from waiting on the watchdog alone.
	task automatic run_xfer(input logic l, input logic a, input logic t, output int n, output logic tcl,
		output logic tcl2);
		// Let the far end's syncs drain the last transfer's count before sampling starts.
		tick(3);
		clr();
		n = 0;
		tcl = 1'b0;
		tcl2 = 1'b0;
		last = l;
		auto = a;
		term = t;
		start = 1'b1;
		tick(1);
		start = 1'b0;
		term = 1'b0;
		chk1("xfer_busy", 1'b1, xbusy);
		while (done !== 1'b1 && n < 40) begin
			if (lk.ctrl_aen === 1'b1) begin
				tcl = lk.ctrl_eop_out;
			end
			if (lk2.ctrl_aen === 1'b1) begin
				tcl2 = lk2.ctrl_eop_out;
			end
			tick(1);
			n++;
		end
	endtask
	task automatic t_reset;
		chk1("eop_oe_n", 1'b0, lk.ctrl_eop_oe_n);
		chk1("eop_line", 1'b0, lk.eop_line);
		chk1("ref_oe_n", 1'b1, lk.ctrl_ref_oe_n);
		chk1("refresh_line_n", 1'b1, lk.refresh_line_n);
		chk1("tc2_oe_n_reset", 1'b0, lk2.ctrl_eop_oe_n);
		$display("t_reset done");
	endtask
	task automatic t_xfer(input logic l, input logic a);
		int n;
		logic tcl;
		logic tcl2;
		run_xfer(l, a, 1'b0, n, tcl, tcl2);
		chkn("xfer_len", XC + 2, n);
		chk1("tc_seen", l, s_tc);
		chk1("tc_last_aen", l & ~a, tcl);
		chk1("tc2_last_aen", l & ~a, tcl2);
		chk1("tc2_oe_n", 1'b0, s_oe2);
		chk1("eop_after", 1'b0, lk.eop_line);
		$display("t_xfer done last %b auto %b", l, a);
	endtask
	task automatic t_term;
		int n;
		logic tcl;
		logic tcl2;
		run_xfer(1'b0, 1'b0, 1'b1, n, tcl, tcl2);
		chk1("terminated", 1'b1, s_term);
		chk1("early_end", 1'b1, n < XC + 2);
		chk1("tc2_runs_on", 1'b1, lk2.ctrl_aen);
		$display("t_term done");
	endtask
	task automatic t_refuse;
		clr();
		act = 1'b0;
		start = 1'b1;
		tick(1);
		chk1("busy_refused", 1'b0, xbusy);
		start = 1'b0;
		tick(4);
		act = 1'b1;
		chk1("aen_refused", 1'b0, s_aen);
		chk1("eop_driven", 1'b0, lk.ctrl_eop_oe_n);
		$display("t_refuse done");
	endtask
	task automatic t_cref;
		clr();
		c_ref = 1'b1;
		tick(1);
		c_ref = 1'b0;
		tick(5);
		chk1("refresh_busy", 1'b1, rbusy);
		chk1("row_refresh", 1'b1, row);
		chk1("data_quiet", 1'b0, dde);
		tick(11);
		chkn("ref_low", DMATR_REF_CYCLES, low_n);
		chk1("own_drive", 1'b1, s_own);
		chk1("ext_seen", 1'b0, s_ext);
		chk1("released", 1'b1, lk.refresh_line_n);
		$display("t_cref done");
	endtask
	task automatic t_pref;
		clr();
		p_ref = 1'b1;
		tick(1);
		p_ref = 1'b0;
		tick(5);
		chk1("refresh_seen", 1'b1, rsn);
		tick(11);
		chkn("ref_low", DMATR_REF_CYCLES, low_n);
		chk1("ext_seen", 1'b1, s_ext);
		chk1("own_drive", 1'b0, s_own);
		$display("t_pref done");
	endtask
	initial begin
		#(3000 * 50);
		error_cnt++;
		report_and_stop();
	end
	initial begin
		tick(8);
		reset_n_in = 1'b1;
		tick(1);
		t_reset();
		for (int i = 0; i < 4; i++) begin
			t_xfer(i[0], i[1]);
		end
		t_term();
		t_refuse();
		t_cref();
		t_pref();
		start = 1'b1;
		tick(3);
		start = 1'b0;
		reset_n_in = 1'b0;
		tick(3);
		reset_n_in = 1'b1;
		tick(1);
		t_reset();
		report_and_stop();
	end
endmodule // dma_termination_and_refresh_tb_top
`default_nettype wire
